// ===== sarsr_adc_serial_readout.sv
// Purpose: Conversion start and serial result readout of a 14-bit converter
// Assumes: Master clock and strobes come from outside and are synchronised here
// Notes:   Pin sampling costs two to three system cycles of latency
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Idle-high start: low 22 clocks, then high
// - Idle-low start: short low pulse, up to two clocks
// - Idle-low mode: frame sync fall drives result MSB quickly
// - Idle-high mode: MSB follows a master clock rise
// - Data changes on rise, stable at serial clock fall
// - Idle-high mode: start strobe rising releases the data line
// - Frame sync rising releases the data line
// - First bit of the frame flags out-of-range input
module sarsr_adc_serial_readout #(
	parameter int unsigned CONV_MCLKS = sarsr_pkg::CONV_MCLKS
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        master_clock,
	input  wire logic        conversion_start_n,
	input  wire logic        transfer_frame_sync_n,
	input  wire logic [13:0] sample_code,
	input  wire logic        sample_overrange,
	output var  logic        serial_clock_out,
	output var  logic        serial_data_out,
	output var  logic        serial_data_oe,
	output var  logic        conv_busy
);
	localparam int unsigned FB = sarsr_pkg::FRAME_BITS;

	logic       rst_meta_reg;
	logic       rst_sync_reg;
	logic [2:0] pin_q;
	logic       mclk_s;
	logic       cs_s;
	logic       tfs_s;
	logic       mclk_d_reg;
	logic       cs_d_reg;
	logic       tfs_d_reg;
	logic       mclk_rise;
	logic       cs_fall;
	logic       cs_rise;
	logic       tfs_fall;
	logic       tfs_rise;

	// Reset is asserted at once and released through two flops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// Strobes idle high at reset so no false edge is seen
	sarsr_sync #(.W(3), .RST_V(3'b110)) u_pin_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_sync_reg),
		.d       ({transfer_frame_sync_n, conversion_start_n, master_clock}),
		.q       (pin_q)
	);
	assign mclk_s = pin_q[0];
	assign cs_s   = pin_q[1];
	assign tfs_s  = pin_q[2];

	always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			mclk_d_reg <= 1'b0;
			cs_d_reg   <= 1'b1;
			tfs_d_reg  <= 1'b1;
		end else begin
			mclk_d_reg <= mclk_s;
			cs_d_reg   <= cs_s;
			tfs_d_reg  <= tfs_s;
		end
	end
	assign mclk_rise = mclk_s & ~mclk_d_reg;
	assign cs_fall   = ~cs_s & cs_d_reg;
	assign cs_rise   = cs_s & ~cs_d_reg;
	assign tfs_fall  = ~tfs_s & tfs_d_reg;
	assign tfs_rise  = tfs_s & ~tfs_d_reg;

	// Conversion engine and mode detection
	logic        busy_reg, busy_next;
	logic [4:0]  conv_cnt_reg, conv_cnt_next;
	logic [14:0] hold_reg, hold_next;
	logic [14:0] result_reg, result_next;
	logic [1:0]  low_cnt_reg, low_cnt_next;
	logic        mode1_reg, mode1_next;
	logic        done_pulse;

	always_comb begin
		busy_next     = busy_reg;
		conv_cnt_next = conv_cnt_reg;
		hold_next     = hold_reg;
		result_next   = result_reg;
		low_cnt_next  = low_cnt_reg;
		mode1_next    = mode1_reg;
		done_pulse    = 1'b0;
		if (cs_fall) begin
			// Sample taken on the start fall; a fall mid-conversion restarts it
			hold_next     = {sample_overrange, sample_code};
			busy_next     = 1'b1;
			conv_cnt_next = 5'h00;
			low_cnt_next  = 2'h0;
		end else if (busy_reg && mclk_rise) begin
			if (conv_cnt_reg == 5'(CONV_MCLKS - 1)) begin
				busy_next   = 1'b0;
				result_next = hold_reg;
				done_pulse  = 1'b1;
			end else begin
				conv_cnt_next = conv_cnt_reg + 5'h01;
			end
		end
		// Low beyond the short-pulse limit means the idle-high mode
		if (!cs_s && !cs_fall && mclk_rise && low_cnt_reg != 2'h3) begin
			low_cnt_next = low_cnt_reg + 2'h1;
			if (low_cnt_reg == 2'(sarsr_pkg::MODE2_LOW_MCLKS))
				mode1_next = 1'b1;
		end
		if (cs_rise && low_cnt_reg <= 2'(sarsr_pkg::MODE2_LOW_MCLKS))
			mode1_next = 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			busy_reg     <= 1'b0;
			conv_cnt_reg <= 5'h00;
			hold_reg     <= sarsr_pkg::RESULT_RST;
			result_reg   <= sarsr_pkg::RESULT_RST;
			low_cnt_reg  <= 2'h0;
			mode1_reg    <= 1'b0;
		end else begin
			busy_reg     <= busy_next;
			conv_cnt_reg <= conv_cnt_next;
			hold_reg     <= hold_next;
			result_reg   <= result_next;
			low_cnt_reg  <= low_cnt_next;
			mode1_reg    <= mode1_next;
		end
	end

	// Serial readout
	sarsr_pkg::sarsr_state_e st_reg, st_next;
	logic [14:0] shift_reg, shift_next;
	logic [3:0]  bit_cnt_reg, bit_cnt_next;
	logic        sdo_reg, sdo_next;
	logic        oe_reg, oe_next;
	logic        sco_reg;
	logic        mode1_start;

	// A start fall in the same cycle must not reuse the count of the previous pulse
	assign mode1_start = !cs_s && !cs_fall && mclk_rise && low_cnt_reg == 2'(sarsr_pkg::MODE2_LOW_MCLKS);

	always_comb begin
		st_next      = st_reg;
		shift_next   = shift_reg;
		bit_cnt_next = bit_cnt_reg;
		sdo_next     = sdo_reg;
		oe_next      = oe_reg;
		unique case (st_reg)
			sarsr_pkg::SARSR_ST_IDLE: begin
				if (mode1_start) begin
					// Previous result goes out while the start strobe stays low
					sdo_next     = result_reg[14];
					shift_next   = {result_reg[13:0], 1'b0};
					oe_next      = 1'b1;
					bit_cnt_next = 4'h1;
					st_next      = sarsr_pkg::SARSR_ST_SHIFT;
				end else if (!mode1_reg && (tfs_fall || (done_pulse && !tfs_s))) begin
					// A tied-low frame sync starts the frame at conversion end
					st_next = sarsr_pkg::SARSR_ST_WAIT;
				end
			end
			sarsr_pkg::SARSR_ST_WAIT: begin
				// MSB is driven at once, within the frame-sync limit
				sdo_next     = (busy_reg ? hold_reg[14] : result_reg[14]);
				shift_next   = busy_reg ? {hold_reg[13:0], 1'b0} : {result_reg[13:0], 1'b0};
				oe_next      = 1'b1;
				bit_cnt_next = 4'h1;
				st_next      = sarsr_pkg::SARSR_ST_SHIFT;
			end
			sarsr_pkg::SARSR_ST_SHIFT: begin
				if (mclk_rise) begin
					// Bits move on the clock rise, so they sit still at the fall
					if (bit_cnt_reg == 4'(FB)) begin
						oe_next = 1'b0;
						st_next = sarsr_pkg::SARSR_ST_IDLE;
					end else begin
						sdo_next     = shift_reg[14];
						shift_next   = {shift_reg[13:0], 1'b0};
						bit_cnt_next = bit_cnt_reg + 4'h1;
					end
				end
			end
			default: st_next = sarsr_pkg::SARSR_ST_IDLE;
		endcase
		// Releases win over any shifting in the same cycle
		if ((cs_rise && mode1_reg) || tfs_rise) begin
			oe_next = 1'b0;
			st_next = sarsr_pkg::SARSR_ST_IDLE;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			st_reg      <= sarsr_pkg::SARSR_ST_IDLE;
			shift_reg   <= sarsr_pkg::RESULT_RST;
			bit_cnt_reg <= 4'h0;
			sdo_reg     <= 1'b0;
			oe_reg      <= 1'b0;
			sco_reg     <= 1'b0;
		end else begin
			st_reg      <= st_next;
			shift_reg   <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
			sdo_reg     <= sdo_next;
			oe_reg      <= oe_next;
			sco_reg     <= mclk_s;
		end
	end

	assign serial_clock_out = sco_reg;
	assign serial_data_out  = sdo_reg;
	assign serial_data_oe   = oe_reg;
	assign conv_busy        = busy_reg;
endmodule // sarsr_adc_serial_readout
`default_nettype wire

// ===== sarsr_pkg.sv
// Purpose: Shared constants for the converter start and serial readout block
// Assumes: System clock of 250 MHz; pins sampled through two flip-flops
// Notes:   Times are in ns; cycle counts are derived from the clock period
package sarsr_pkg;
	localparam int unsigned CLK_PERIOD_NS    = 4;
	localparam int unsigned RESULT_BITS      = 14;
	localparam int unsigned FRAME_BITS       = RESULT_BITS + 1;
	localparam int unsigned CONV_MCLKS       = 24;
	localparam int unsigned MODE1_LOW_MCLKS  = 22;
	localparam int unsigned MODE2_LOW_MCLKS  = 2;
	localparam int unsigned T_HIGH_MIN_NS    = 10;
	localparam int unsigned T_TFS_MSB_NS     = 30;
	localparam int unsigned T_MCLK_MSB_NS    = 15;
	localparam int unsigned T_CS_RELEASE_NS  = 6;
	localparam int unsigned T_TFS_RELEASE_NS = 8;
	// Longest times round down, least times round up, none below one cycle
	localparam int unsigned TFS_MSB_CYC      = (T_TFS_MSB_NS / CLK_PERIOD_NS) > 0 ?
		(T_TFS_MSB_NS / CLK_PERIOD_NS) : 1;
	localparam int unsigned MCLK_MSB_CYC     = (T_MCLK_MSB_NS / CLK_PERIOD_NS) > 0 ?
		(T_MCLK_MSB_NS / CLK_PERIOD_NS) : 1;
	localparam int unsigned CS_RELEASE_CYC   = (T_CS_RELEASE_NS / CLK_PERIOD_NS) > 0 ?
		(T_CS_RELEASE_NS / CLK_PERIOD_NS) : 1;
	localparam int unsigned TFS_RELEASE_CYC  = (T_TFS_RELEASE_NS / CLK_PERIOD_NS) > 0 ?
		(T_TFS_RELEASE_NS / CLK_PERIOD_NS) : 1;
	localparam int unsigned HIGH_MIN_CYC     = (T_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [14:0] RESULT_RST       = 15'h0000;

	typedef enum logic [1:0] {
		SARSR_ST_IDLE  = 2'b00,
		SARSR_ST_WAIT  = 2'b01,
		SARSR_ST_SHIFT = 2'b10
	} sarsr_state_e;
endpackage

// ===== sarsr_sync.sv
// Purpose: Two flip-flop synchroniser for a group of pin inputs
// Assumes: Each bit is an independent level
// Notes:   First stage is read by the second stage only
`timescale 1ns/100ps
`default_nettype none
module sarsr_sync #(
	parameter int unsigned W      = 1,
	parameter logic [W-1:0] RST_V = '0
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= RST_V;
			q        <= RST_V;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule // sarsr_sync
`default_nettype wire

// ===== sarsr_chk_sva.sv
// Purpose: Port assertions for the start and readout block
// Assumes: Pin inputs change away from the rising clock edge
// Notes:   Windows allow for the two-flop pin sync lag
`timescale 1ns/100ps
`default_nettype none
module sarsr_chk #(
	parameter int unsigned CONV_MCLKS = 24
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic master_clock,
	input wire logic conversion_start_n,
	input wire logic transfer_frame_sync_n,
	input wire logic serial_clock_out,
	input wire logic serial_data_out,
	input wire logic serial_data_oe,
	input wire logic conv_busy
);
	logic [7:0] rise_cnt_reg;
	logic [7:0] rise_cnt_next;
	logic       mclk_reg;
	// Pin rises are counted before the design sees them, so the last one lands while busy
	always_comb begin
		rise_cnt_next = conv_busy ? rise_cnt_reg + {7'h00, master_clock & ~mclk_reg} : 8'h00;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rise_cnt_reg <= 8'h00;
			mclk_reg     <= 1'h0;
		end else begin
			rise_cnt_reg <= rise_cnt_next;
			mclk_reg     <= master_clock;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	property p_start; $fell(conversion_start_n) |-> ##[2:6] conv_busy; endproperty
	a_start: assert property (p_start) else $error("start missed");
	property p_len; $fell(conv_busy) |-> rise_cnt_reg == 8'(CONV_MCLKS); endproperty
	a_len: assert property (p_len) else $error("conversion length");
	property p_sco; $past(rst_n, 6) |-> serial_clock_out == $past(master_clock, 3); endproperty
	a_sco: assert property (p_sco) else $error("serial clock lag");
	property p_hold;
		serial_data_oe && $past(serial_data_oe, 3) && $fell(serial_clock_out)
			|-> serial_data_out == $past(serial_data_out, 3) ##1 $stable(serial_data_out) [*4];
	endproperty
	a_hold: assert property (p_hold) else $error("data moved at clock fall");
	property p_csrel; $rose(conversion_start_n) |-> ##[1:5] !serial_data_oe; endproperty
	a_csrel: assert property (p_csrel) else $error("line kept after start rise");
	property p_fsrel; $rose(transfer_frame_sync_n) |-> ##[1:5] !serial_data_oe; endproperty
	a_fsrel: assert property (p_fsrel) else $error("line kept after sync rise");
	property p_fsmsb; $fell(transfer_frame_sync_n) |-> ##[2:7] serial_data_oe; endproperty
	a_fsmsb: assert property (p_fsmsb) else $error("first bit late after sync");
	property p_mcmsb;
		$rose(serial_data_oe) && !conversion_start_n && transfer_frame_sync_n
			|-> $past(master_clock, 2) && !$past(master_clock, 7);
	endproperty
	a_mcmsb: assert property (p_mcmsb) else $error("first bit not after clock rise");
	c_mode1: cover property ($rose(serial_data_oe) && !conversion_start_n && transfer_frame_sync_n);
	c_csabort: cover property ($rose(conversion_start_n) && serial_data_oe);
	c_fsabort: cover property ($rose(transfer_frame_sync_n) && serial_data_oe);
endmodule // sarsr_chk
`default_nettype wire

// ===== sarsr_ctrl_model.sv
// Purpose: Controller model driving the strobes and capturing frames
// Assumes: Master clock of 160 ns runs free, since conversion needs it
// Notes:   A released line reads as the inverse of the last bit taken
`timescale 1ns/100ps
`default_nettype none
module sarsr_ctrl_model (
	input  wire logic clk_sys,
	input  wire logic serial_clock_out,
	input  wire logic serial_data_out,
	input  wire logic serial_data_oe,
	output var  logic master_clock,
	output var  logic conversion_start_n,
	output var  logic transfer_frame_sync_n
);
	logic [14:0] frame_word = 15'h0000;
	logic        armed = 1'h0;
	logic        active = 1'h0;
	logic        sco_q = 1'h0;
	logic        oe_q = 1'h0;
	int          half_cnt = 0;
	int          bit_cnt = 0;
	wire logic   frame_done = (bit_cnt == 15);
	initial begin
		master_clock = 1'h0;
		conversion_start_n = 1'h1;
		transfer_frame_sync_n = 1'h1;
	end
	always @(negedge clk_sys) begin
		half_cnt <= (half_cnt == 19) ? 0 : half_cnt + 1;
		if (half_cnt == 19)
			master_clock <= ~master_clock;
	end
	always @(posedge clk_sys) begin
		sco_q <= serial_clock_out;
		oe_q  <= serial_data_oe;
		// Only a fresh rise of the enable opens a frame, so a tail of the last one is not taken
		if (armed && serial_data_oe && !oe_q) begin
			active <= 1'h1;
			armed  <= 1'h0;
		end
		if (active && sco_q && !serial_clock_out && bit_cnt < 15) begin
			frame_word <= {frame_word[13:0], serial_data_oe ? serial_data_out : ~frame_word[0]};
			bit_cnt    <= bit_cnt + 1;
		end
	end
	task automatic arm();
		armed = 1'h1;
		active = 1'h0;
		bit_cnt = 0;
	endtask
	// Fall mid low phase keeps clear of the next clock rise
	task automatic start(input int mclks);
		@(negedge master_clock);
		repeat (10) @(negedge clk_sys);
		conversion_start_n = 1'h0;
		repeat (mclks * 40) @(negedge clk_sys);
		conversion_start_n = 1'h1;
	endtask
	// Just after a rise, so the first bit is seen at the next serial clock fall
	task automatic frame_sync(input logic v);
		@(posedge master_clock);
		repeat (2) @(negedge clk_sys);
		transfer_frame_sync_n = v;
	endtask
endmodule // sarsr_ctrl_model
`default_nettype wire

// ===== sarsr_tb.sv
// Purpose: Self-checking bench for the start and readout block
// Assumes: Inputs change on the falling clock edge
// Notes:   Conversion waits use the fixed conversion length
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam int CONV = sarsr_pkg::CONV_MCLKS;
	logic        clk_sys = 1'h0;
	logic        rst_n = 1'h0;
	logic [13:0] sample_code = 14'h0000;
	logic        sample_overrange = 1'h0;
	logic        master_clock;
	logic        conversion_start_n;
	logic        transfer_frame_sync_n;
	logic        serial_clock_out;
	logic        serial_data_out;
	logic        serial_data_oe;
	logic        conv_busy;
	int          failures = 0;
	int          checks = 0;
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	sarsr_adc_serial_readout #(
		.CONV_MCLKS (CONV)
	) dut (
		.clk_sys               (clk_sys),
		.rst_n                 (rst_n),
		.master_clock          (master_clock),
		.conversion_start_n    (conversion_start_n),
		.transfer_frame_sync_n (transfer_frame_sync_n),
		.sample_code           (sample_code),
		.sample_overrange      (sample_overrange),
		.serial_clock_out      (serial_clock_out),
		.serial_data_out       (serial_data_out),
		.serial_data_oe        (serial_data_oe),
		.conv_busy             (conv_busy)
	);
	sarsr_ctrl_model u_ctrl (
		.clk_sys               (clk_sys),
		.serial_clock_out      (serial_clock_out),
		.serial_data_out       (serial_data_out),
		.serial_data_oe        (serial_data_oe),
		.master_clock          (master_clock),
		.conversion_start_n    (conversion_start_n),
		.transfer_frame_sync_n (transfer_frame_sync_n)
	);
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("failures=%0d checks=%0d", failures, checks);
		if (failures == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wait_frame(input logic [14:0] exp);
		int n;
		for (n = 0; n < 4000 && u_ctrl.frame_done !== 1'h1; n++)
			@(negedge clk_sys);
		check({15'h0000, n < 4000}, 16'h0001);
		if (n == 4000)
			print_verdict();
		else
			check({1'h0, u_ctrl.frame_word}, {1'h0, exp});
	endtask
	task automatic s_tied();
		u_ctrl.arm();
		u_ctrl.frame_sync(1'h0);
		wait_frame(sarsr_pkg::RESULT_RST);
		u_ctrl.arm();
		sample_code = 14'h2A5C;
		u_ctrl.start(1);
		wait_frame({1'h0, 14'h2A5C});
		u_ctrl.frame_sync(1'h1);
	endtask
	task automatic s_pulsed();
		sample_code = 14'h3FFF;
		sample_overrange = 1'h1;
		u_ctrl.start(1);
		check({15'h0000, conv_busy}, 16'h0001);
		repeat (CONV * 40 + 80) @(negedge clk_sys);
		check({15'h0000, conv_busy}, 16'h0000);
		u_ctrl.arm();
		u_ctrl.frame_sync(1'h0);
		wait_frame({1'h1, 14'h3FFF});
		repeat (320) @(negedge clk_sys);
		u_ctrl.frame_sync(1'h1);
	endtask
	// Frame sync is cut short on purpose to see the line let go mid-frame
	task automatic s_fs_abort();
		sample_code = 14'h0001;
		sample_overrange = 1'h0;
		u_ctrl.start(1);
		repeat (CONV * 40 + 80) @(negedge clk_sys);
		u_ctrl.frame_sync(1'h0);
		repeat (240) @(negedge clk_sys);
		check({15'h0000, serial_data_oe}, 16'h0001);
		u_ctrl.frame_sync(1'h1);
		repeat (6) @(negedge clk_sys);
		check({15'h0000, serial_data_oe}, 16'h0000);
	endtask
	task automatic s_mode1();
		sample_code = 14'h1234;
		u_ctrl.arm();
		u_ctrl.start(22);
		wait_frame({1'h0, 14'h0001});
		repeat (CONV * 40) @(negedge clk_sys);
		u_ctrl.start(8);
		repeat (6) @(negedge clk_sys);
		check({15'h0000, serial_data_oe}, 16'h0000);
	endtask
	initial begin
		repeat (8) @(negedge clk_sys);
		rst_n = 1'h1;
		repeat (4) @(negedge clk_sys);
		s_tied();
		s_pulsed();
		s_fs_abort();
		s_mode1();
		print_verdict();
	end
endmodule // tb
bind sarsr_adc_serial_readout sarsr_chk #(
	.CONV_MCLKS (CONV_MCLKS)
) u_chk (
	.clk_sys               (clk_sys),
	.rst_n                 (rst_n),
	.master_clock          (master_clock),
	.conversion_start_n    (conversion_start_n),
	.transfer_frame_sync_n (transfer_frame_sync_n),
	.serial_clock_out      (serial_clock_out),
	.serial_data_out       (serial_data_out),
	.serial_data_oe        (serial_data_oe),
	.conv_busy             (conv_busy)
);
`default_nettype wire
